/* core/mscr_access_map.sv */
// mscr_access_map: decodes which peripheral owns a shared address and
// whether timer and usb register access is allowed.
// assumes: purely combinational, fed from the bank's own registers.
`timescale 1ns/10ps
`default_nettype none
module mscr_access_map
  import mscr_pkg::*;
(
  // controls
  input wire logic host_if_enable_in,
  input wire logic twowire_master_enable_in,
  input wire logic usb_access_enable_in,
  // address
  input wire logic [15:0] addr_in,
  // selects
  output logic timer_access_out,
  output logic serial_channel0_sel_out,
  output logic twowire_channel0_sel_out,
  output logic twowire_channel1_sel_out,
  output logic pulse_width_dac_sel_out,
  output logic usb_access_out
);
  function automatic logic pair_hit(input logic [15:0] a, input logic [15:0] b0, input logic [15:0] b1);
    pair_hit = (a[15:1] == b0[15:1]) || (a[15:1] == b1[15:1]);
  endfunction
  logic shared_d8;
  logic timer_area;
  assign shared_d8 = pair_hit(addr_in, 16'hFFD8, 16'hFFDE);
  assign timer_area = (addr_in >= 16'hFFF0 && addr_in <= 16'hFFF7) || addr_in >= 16'hFFFC;
  assign timer_access_out = timer_area && !host_if_enable_in;
  assign serial_channel0_sel_out = shared_d8 && !twowire_master_enable_in;
  assign twowire_channel0_sel_out = shared_d8 && twowire_master_enable_in;
  assign twowire_channel1_sel_out = pair_hit(addr_in, 16'hFF88, 16'hFF8E) && twowire_master_enable_in;
  assign pulse_width_dac_sel_out = pair_hit(addr_in, 16'hFFA0, 16'hFFA6) && twowire_master_enable_in;
  assign usb_access_out = usb_access_enable_in;
endmodule : mscr_access_map
`default_nettype wire

/* core/mscr_bus_cycle.sv */
// mscr_bus_cycle: paces one peripheral access over three states.
// assumes: a request is held steady from its first state to the done pulse.
`timescale 1ns/10ps
`default_nettype none
module mscr_bus_cycle
  import mscr_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // request
  input wire logic req_in,
  // pacing
  output logic first_state_out,
  output logic last_state_out
);
  logic [1:0] state_cnt;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_cnt <= 2'h0;
    end else if (clk_en_in) begin
      if (!req_in || state_cnt == MSCR_BUS_LAST) begin
        state_cnt <= 2'h0;
      end else begin
        state_cnt <= state_cnt + 2'h1;
      end
    end
  end
  assign first_state_out = req_in && state_cnt == 2'h0;
  assign last_state_out = req_in && state_cnt == MSCR_BUS_LAST;
  property p_bus_three;
    @(posedge clk_in) disable iff (rst_in)
      (clk_en_in && first_state_out) ##1 (clk_en_in && req_in) [*2] |-> last_state_out;
  endproperty
  a_bus_three: assert property (p_bus_three) else $error("access not done in three states");
endmodule : mscr_bus_cycle
`default_nettype wire

/* core/mscr_pkg.sv */
// mscr_pkg: offsets, reset values, field positions and bus timing for the
// mode and system control register bank.
// assumes: used by every file of the bank through mscr_pkg::*.
package mscr_pkg;
  // register addresses, lower 16 bits of the internal bus address
  localparam logic [15:0] MSCR_ADDR_PERIPH_SEL = 16'hFFC3;
  localparam logic [15:0] MSCR_ADDR_SYS_CTRL = 16'hFFC4;
  localparam logic [15:0] MSCR_ADDR_MODE_STAT = 16'hFFC5;
  // reset values
  localparam logic [7:0] MSCR_PERIPH_SEL_RST = 8'h00;
  localparam logic [7:0] MSCR_SYS_CTRL_RST = 8'h09;
  localparam logic [7:0] MSCR_MODE_STAT_RST = 8'h03;
  // system control field positions
  localparam int MSCR_SC_CHIP_SELECT2_ENABLE = 7;
  localparam int MSCR_SC_ALT_STROBE_ENABLE = 6;
  localparam int MSCR_SC_IRQ_CTRL_MODE_HI = 5;
  localparam int MSCR_SC_IRQ_CTRL_MODE_LO = 4;
  localparam int MSCR_SC_RESET_SOURCE_FLAG = 3;
  localparam int MSCR_SC_NMI_EDGE_SELECT = 2;
  localparam int MSCR_SC_HOST_IF_ENABLE = 1;
  localparam int MSCR_SC_RAM_ENABLE = 0;
  // software-writable bits of system control
  localparam logic [7:0] MSCR_SC_WR_MASK = 8'hC7;
  // peripheral access select field positions
  localparam int MSCR_PS_TWOWIRE_CTRL_HI = 6;
  localparam int MSCR_PS_TWOWIRE_CTRL_LO = 5;
  localparam int MSCR_PS_TWOWIRE_MASTER_ENABLE = 4;
  localparam int MSCR_PS_USB_ACCESS_ENABLE = 2;
  localparam int MSCR_PS_INT_CLK_SEL_HI = 1;
  localparam int MSCR_PS_INT_CLK_SEL_LO = 0;
  // mode status register layout
  localparam int MSCR_MS_MODE_STATUS_HI = 1;
  localparam int MSCR_MS_MODE_STATUS_LO = 0;
  // peripheral bus cycle length in states
  localparam int MSCR_BUS_STATES = 3;
  localparam logic [1:0] MSCR_BUS_LAST = 2'(MSCR_BUS_STATES - 1);
  // operating modes decoded from the straps
  typedef enum logic [1:0] {
    MSCR_MODE0,
    MSCR_MODE1,
    MSCR_MODE2,
    MSCR_MODE3
  } mscr_mode_e;
endpackage : mscr_pkg

/* core/mscr_regs.sv */
// mscr_regs: mode status, system control and peripheral access select bank.
// assumes: wdt_reset_in pulses with rst_in when the watchdog caused the reset;
// the cpu holds bus requests for the whole three-state cycle.
`timescale 1ns/10ps
`default_nettype none
module mscr_regs
  import mscr_pkg::*;
#(
  parameter bit SINGLE_TEST_PIN = 1'b0
) (
  // clock, reset, standby
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic hw_standby_in,
  input wire logic wdt_reset_in,
  // mode straps
  input wire logic mode_strap_hi_in,
  input wire logic mode_strap_lo_in,
  input wire logic test_n_in,
  // peripheral bus
  input wire logic bus_req_in,
  input wire logic bus_wr_in,
  input wire logic [15:0] bus_addr_in,
  input wire logic [7:0] bus_wdata_in,
  output logic [7:0] bus_rdata_out,
  output logic bus_hit_out,
  output logic bus_done_out,
  // system controls
  output mscr_mode_e mode_out,
  output logic ram_enable_out,
  output logic nmi_edge_select_out,
  output logic [1:0] irq_ctrl_mode_out,
  output logic chip_select2_enable_out,
  output logic alt_strobe_enable_out,
  output logic [1:0] twowire_ctrl_out,
  output logic [1:0] int_clk_sel_out,
  // access selects
  output logic timer_access_out,
  output logic serial_channel0_sel_out,
  output logic twowire_channel0_sel_out,
  output logic twowire_channel1_sel_out,
  output logic pulse_width_dac_sel_out,
  output logic usb_access_out
);
  initial begin
    if (SINGLE_TEST_PIN !== 1'b0 && SINGLE_TEST_PIN !== 1'b1) begin
      $error("SINGLE_TEST_PIN must be 0 or 1");
    end
  end

  logic [7:0] system_control;
  logic [7:0] peripheral_access_select;
  logic [1:0] mode_status;
  logic rst_was_wdt;
  logic first_state;
  logic last_state;
  logic sel_ps;
  logic sel_sc;
  logic sel_ms;
  logic [1:0] strap_lv;

  mscr_bus_cycle u_cycle (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .req_in(bus_req_in),
    .first_state_out(first_state),
    .last_state_out(last_state)
  );

  assign sel_ps = bus_addr_in == MSCR_ADDR_PERIPH_SEL;
  assign sel_sc = bus_addr_in == MSCR_ADDR_SYS_CTRL;
  assign sel_ms = bus_addr_in == MSCR_ADDR_MODE_STAT;
  assign bus_hit_out = bus_req_in && (sel_ps || sel_sc || sel_ms);
  assign bus_done_out = last_state;

  always_comb begin
    if (SINGLE_TEST_PIN) begin
      strap_lv = {test_n_in, test_n_in};
    end else begin
      strap_lv = {mode_strap_hi_in, mode_strap_lo_in};
    end
  end
  assign mode_out = mscr_mode_e'(strap_lv);

  // watchdog cause captured in a clocked process, since reset may not load a port
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rst_was_wdt <= wdt_reset_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_status <= MSCR_MODE_STAT_RST[1:0];
    end else if (clk_en_in && first_state && !bus_wr_in && sel_ms) begin
      mode_status <= strap_lv;
    end
  end

  // system control reset and standby load
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      system_control <= MSCR_SYS_CTRL_RST;
    end else if (hw_standby_in) begin
      system_control <= MSCR_SYS_CTRL_RST;
    end else if (clk_en_in && last_state && bus_wr_in && sel_sc) begin
      system_control <= (system_control & ~MSCR_SC_WR_MASK) | (bus_wdata_in & MSCR_SC_WR_MASK);
    end
  end

  // peripheral access select clear and write
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      peripheral_access_select <= MSCR_PERIPH_SEL_RST;
    end else if (hw_standby_in) begin
      peripheral_access_select <= MSCR_PERIPH_SEL_RST;
    end else if (clk_en_in && last_state && bus_wr_in && sel_ps) begin
      peripheral_access_select <= bus_wdata_in;
    end
  end

  always_comb begin
    bus_rdata_out = 8'h00;
    if (bus_req_in && !bus_wr_in) begin
      if (sel_ps) begin
        bus_rdata_out = peripheral_access_select;
      end else if (sel_sc) begin
        bus_rdata_out = system_control;
        bus_rdata_out[MSCR_SC_RESET_SOURCE_FLAG] = !rst_was_wdt;
      end else if (sel_ms) begin
        bus_rdata_out = {6'h00, mode_status};
      end
    end
  end

  assign ram_enable_out = system_control[MSCR_SC_RAM_ENABLE];
  assign nmi_edge_select_out = system_control[MSCR_SC_NMI_EDGE_SELECT];
  assign irq_ctrl_mode_out = {system_control[MSCR_SC_IRQ_CTRL_MODE_HI], system_control[MSCR_SC_IRQ_CTRL_MODE_LO]};
  // passed out; software keeps them low
  assign chip_select2_enable_out = system_control[MSCR_SC_CHIP_SELECT2_ENABLE];
  assign alt_strobe_enable_out = system_control[MSCR_SC_ALT_STROBE_ENABLE];
  assign twowire_ctrl_out = {peripheral_access_select[MSCR_PS_TWOWIRE_CTRL_HI],
                             peripheral_access_select[MSCR_PS_TWOWIRE_CTRL_LO]};
  assign int_clk_sel_out = {peripheral_access_select[MSCR_PS_INT_CLK_SEL_HI],
                            peripheral_access_select[MSCR_PS_INT_CLK_SEL_LO]};

  mscr_access_map u_map (
    .host_if_enable_in(system_control[MSCR_SC_HOST_IF_ENABLE]),
    .twowire_master_enable_in(peripheral_access_select[MSCR_PS_TWOWIRE_MASTER_ENABLE]),
    .usb_access_enable_in(peripheral_access_select[MSCR_PS_USB_ACCESS_ENABLE]),
    .addr_in(bus_addr_in),
    .timer_access_out(timer_access_out),
    .serial_channel0_sel_out(serial_channel0_sel_out),
    .twowire_channel0_sel_out(twowire_channel0_sel_out),
    .twowire_channel1_sel_out(twowire_channel1_sel_out),
    .pulse_width_dac_sel_out(pulse_width_dac_sel_out),
    .usb_access_out(usb_access_out)
  );

  sequence s_sc_write;
    clk_en_in && last_state && bus_wr_in && sel_sc && !hw_standby_in;
  endsequence

  property p_sc_ro_bits;
    @(posedge clk_in) disable iff (rst_in)
      s_sc_write |=> system_control[5:3] == $past(system_control[5:3]);
  endproperty
  a_sc_ro_bits: assert property (p_sc_ro_bits) else $error("read-only system control bits changed");

  property p_sc_wr;
    @(posedge clk_in) disable iff (rst_in)
      s_sc_write |=> system_control[1:0] == $past(bus_wdata_in[1:0]);
  endproperty
  a_sc_wr: assert property (p_sc_wr) else $error("system control write lost");

  property p_sc_standby;
    @(posedge clk_in) disable iff (rst_in)
      hw_standby_in |=> system_control == 8'h09;
  endproperty
  a_sc_standby: assert property (p_sc_standby) else $error("system control not 09 after standby");

  property p_ps_standby;
    @(posedge clk_in) disable iff (rst_in)
      hw_standby_in |=> peripheral_access_select == 8'h00;
  endproperty
  a_ps_standby: assert property (p_ps_standby) else $error("access select not cleared");

  property p_ms_zero;
    @(posedge clk_in) disable iff (rst_in)
      bus_req_in && !bus_wr_in && sel_ms |-> bus_rdata_out[7:2] == 6'h00;
  endproperty
  a_ms_zero: assert property (p_ms_zero) else $error("mode status upper bits not zero");

  property p_ms_latch;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && first_state && !bus_wr_in && sel_ms |=> mode_status == $past(strap_lv);
  endproperty
  a_ms_latch: assert property (p_ms_latch) else $error("straps not latched on read");

  property p_reset_flag;
    @(posedge clk_in) disable iff (rst_in)
      bus_req_in && !bus_wr_in && sel_sc |-> bus_rdata_out[3] == !rst_was_wdt;
  endproperty
  a_reset_flag: assert property (p_reset_flag) else $error("reset source flag wrong");

  property p_timer_gate;
    @(posedge clk_in) disable iff (rst_in)
      system_control[MSCR_SC_HOST_IF_ENABLE] |-> !timer_access_out;
  endproperty
  a_timer_gate: assert property (p_timer_gate) else $error("timer access while host interface on");

  property p_sci_map;
    @(posedge clk_in) disable iff (rst_in)
      bus_addr_in == 16'hFFD8 |-> serial_channel0_sel_out != peripheral_access_select[4];
  endproperty
  a_sci_map: assert property (p_sci_map) else $error("shared address mapping wrong");

  property p_usb;
    @(posedge clk_in) disable iff (rst_in)
      usb_access_out == peripheral_access_select[2];
  endproperty
  a_usb: assert property (p_usb) else $error("usb access does not follow select bit");

  sequence s_ps_write;
    clk_en_in && last_state && bus_wr_in && sel_ps && !hw_standby_in;
  endsequence

  sequence s_access_start;
    clk_en_in && first_state;
  endsequence

  property p_ps_wr;
    @(posedge clk_in) disable iff (rst_in)
      s_ps_write |=> peripheral_access_select == $past(bus_wdata_in);
  endproperty
  a_ps_wr: assert property (p_ps_wr) else $error("access select write lost");

  property p_ms_ro;
    @(posedge clk_in) disable iff (rst_in)
      clk_en_in && bus_req_in && bus_wr_in && sel_ms |=> $stable(mode_status);
  endproperty
  a_ms_ro: assert property (p_ms_ro) else $error("mode status changed by a write");

  // clock enable low stands in for software standby: no register may move unless hw_standby_in loads the reset values
  property p_freeze;
    @(posedge clk_in) disable iff (rst_in)
      !clk_en_in && !hw_standby_in |=> $stable(system_control) && $stable(peripheral_access_select)
        && $stable(mode_status);
  endproperty
  a_freeze: assert property (p_freeze) else $error("registers moved while clock enable low");

  property p_bus_done;
    @(posedge clk_in) disable iff (rst_in)
      s_access_start ##1 (clk_en_in && bus_req_in) [*2] |-> bus_done_out;
  endproperty
  a_bus_done: assert property (p_bus_done) else $error("bus done missing in third state");

  // no disable here, since this one watches the reset itself
  property p_reset_cause;
    @(posedge clk_in)
      rst_in |=> rst_was_wdt == $past(wdt_reset_in);
  endproperty
  a_reset_cause: assert property (p_reset_cause) else $error("reset cause not captured");

  property p_ram_init;
    @(posedge clk_in)
      $fell(rst_in) |-> ram_enable_out;
  endproperty
  a_ram_init: assert property (p_ram_init) else $error("ram not enabled at reset release");

  property p_ps_init;
    @(posedge clk_in)
      $fell(rst_in) |-> peripheral_access_select == MSCR_PERIPH_SEL_RST;
  endproperty
  a_ps_init: assert property (p_ps_init) else $error("access select not clear at reset release");

  property p_timer_open;
    @(posedge clk_in) disable iff (rst_in)
      !system_control[MSCR_SC_HOST_IF_ENABLE] && bus_addr_in == 16'hFFF0 |-> timer_access_out;
  endproperty
  a_timer_open: assert property (p_timer_open) else $error("timer access blocked with host interface off");

  property p_tw1_map;
    @(posedge clk_in) disable iff (rst_in)
      bus_addr_in == 16'hFF88 |->
        twowire_channel1_sel_out == peripheral_access_select[MSCR_PS_TWOWIRE_MASTER_ENABLE];
  endproperty
  a_tw1_map: assert property (p_tw1_map) else $error("two-wire channel 1 mapping wrong");

  property p_dac_map;
    @(posedge clk_in) disable iff (rst_in)
      bus_addr_in == 16'hFFA6 |->
        pulse_width_dac_sel_out == peripheral_access_select[MSCR_PS_TWOWIRE_MASTER_ENABLE];
  endproperty
  a_dac_map: assert property (p_dac_map) else $error("dac mapping wrong");
endmodule : mscr_regs
`default_nettype wire

/* sim/test_mscr_regs.sv */
// test_mscr_regs: self-checking bench for the mode and system control bank.
// assumes: two-strap variant plus a single test-pin copy; the bank's own assertions sit in the design files.
`timescale 1ns/10ps
`default_nettype none
module test_mscr_regs
  import mscr_pkg::*;
;
  localparam logic [15:0] PS = MSCR_ADDR_PERIPH_SEL;
  localparam logic [15:0] SC = MSCR_ADDR_SYS_CTRL;
  localparam logic [15:0] MS = MSCR_ADDR_MODE_STAT;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic hw_standby_in = 1'b0;
  logic wdt_reset_in = 1'b0;
  logic mode_strap_hi_in = 1'b1;
  logic mode_strap_lo_in = 1'b1;
  logic test_n_in = 1'b1;
  logic bus_req_in = 1'b0;
  logic bus_wr_in = 1'b0;
  logic [15:0] bus_addr_in = 16'h0000;
  logic [7:0] bus_wdata_in = 8'h00;
  logic [7:0] bus_rdata_out;
  logic bus_hit_out, bus_done_out, ram_enable_out, nmi_edge_select_out;
  logic chip_select2_enable_out, alt_strobe_enable_out;
  logic [1:0] irq_ctrl_mode_out, twowire_ctrl_out, int_clk_sel_out;
  logic timer_access_out, serial_channel0_sel_out, twowire_channel0_sel_out;
  logic twowire_channel1_sel_out, pulse_width_dac_sel_out, usb_access_out;
  mscr_mode_e mode_out;
  mscr_mode_e tp_mode;
  logic [7:0] tp_rdata;
  logic [7:0] tpq[$];
  int miscompares = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'h50362AA5;
  logic [7:0] expq[$];
  logic [15:0] amap [12] = '{16'hFFF0, 16'hFFF7, 16'hFFF8, 16'hFFFC, 16'hFFFF, 16'hFFD8,
                             16'hFFDF, 16'hFFDA, 16'hFF88, 16'hFF8F, 16'hFFA1, 16'hFFA6};

  mscr_regs #(.SINGLE_TEST_PIN(1'b0)) u_mscr_regs (
    .clk_in(clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in), .hw_standby_in(hw_standby_in),
    .wdt_reset_in(wdt_reset_in), .mode_strap_hi_in(mode_strap_hi_in), .mode_strap_lo_in(mode_strap_lo_in),
    .test_n_in(test_n_in), .bus_req_in(bus_req_in), .bus_wr_in(bus_wr_in), .bus_addr_in(bus_addr_in),
    .bus_wdata_in(bus_wdata_in), .bus_rdata_out(bus_rdata_out), .bus_hit_out(bus_hit_out),
    .bus_done_out(bus_done_out), .mode_out(mode_out), .ram_enable_out(ram_enable_out),
    .nmi_edge_select_out(nmi_edge_select_out), .irq_ctrl_mode_out(irq_ctrl_mode_out),
    .chip_select2_enable_out(chip_select2_enable_out), .alt_strobe_enable_out(alt_strobe_enable_out),
    .twowire_ctrl_out(twowire_ctrl_out), .int_clk_sel_out(int_clk_sel_out),
    .timer_access_out(timer_access_out), .serial_channel0_sel_out(serial_channel0_sel_out),
    .twowire_channel0_sel_out(twowire_channel0_sel_out), .twowire_channel1_sel_out(twowire_channel1_sel_out),
    .pulse_width_dac_sel_out(pulse_width_dac_sel_out), .usb_access_out(usb_access_out)
  );

  // single test-pin variant on the same bus; straps wiggle but must be ignored
  if (1) begin : g_test_pin
    mscr_regs #(.SINGLE_TEST_PIN(1'b1)) u_mscr_regs (
      .clk_in(clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in), .hw_standby_in(hw_standby_in),
      .wdt_reset_in(wdt_reset_in), .mode_strap_hi_in(mode_strap_hi_in), .mode_strap_lo_in(mode_strap_lo_in),
      .test_n_in(test_n_in), .bus_req_in(bus_req_in), .bus_wr_in(bus_wr_in), .bus_addr_in(bus_addr_in),
      .bus_wdata_in(bus_wdata_in), .bus_rdata_out(tp_rdata), .bus_hit_out(), .bus_done_out(),
      .mode_out(tp_mode), .ram_enable_out(), .nmi_edge_select_out(), .irq_ctrl_mode_out(),
      .chip_select2_enable_out(), .alt_strobe_enable_out(), .twowire_ctrl_out(), .int_clk_sel_out(),
      .timer_access_out(), .serial_channel0_sel_out(), .twowire_channel0_sel_out(),
      .twowire_channel1_sel_out(), .pulse_width_dac_sel_out(), .usb_access_out()
    );
  end

  always #4 clk_in = ~clk_in;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic rnd(output logic [7:0] v);
    seed = xs(seed);
    v = seed[7:0];
  endtask

  function automatic logic [7:0] exp_map(input logic [15:0] a, input logic host_if, input logic tw_master);
    logic sh;
    sh = a inside {16'hFFD8, 16'hFFD9, 16'hFFDE, 16'hFFDF};
    return {3'h0, !host_if && ((a >= 16'hFFF0 && a <= 16'hFFF7) || a >= 16'hFFFC),
            sh && !tw_master, sh && tw_master,
            tw_master && (a inside {16'hFF88, 16'hFF89, 16'hFF8E, 16'hFF8F}),
            tw_master && (a inside {16'hFFA0, 16'hFFA1, 16'hFFA6, 16'hFFA7})};
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    if (miscompares == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // starts on a falling edge; keep leaves the request up for a back-to-back access
  task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic [7:0] e,
                        input logic keep);
    int n;
    bus_req_in = 1'b1;
    bus_wr_in = wr;
    bus_addr_in = a;
    bus_wdata_in = d;
    if (!wr) expq.push_back(e);
    n = 0;
    // count enabled edges until done shows; stalled edges do not count
    while (!(bus_done_out === 1'b1 && clk_en_in === 1'b1) && n < 20) begin
      @(posedge clk_in);
      if (clk_en_in === 1'b1) n++;
      @(negedge clk_in);
    end
    check(8'(n), 8'(MSCR_BUS_STATES - 1), "bus cycle length");
    @(posedge clk_in);
    @(negedge clk_in);
    if (!keep) begin
      bus_req_in = 1'b0;
      bus_wr_in = 1'b0;
      @(negedge clk_in);
    end
  endtask

  task automatic do_reset(input logic wdt);
    rst_in = 1'b1;
    wdt_reset_in = wdt;
    repeat (5) @(negedge clk_in);
    rst_in = 1'b0;
    wdt_reset_in = 1'b0;
    @(negedge clk_in);
  endtask

  // read results are taken off the queue at the edge that ends the access
  always @(posedge clk_in) begin
    if (bus_done_out === 1'b1 && clk_en_in === 1'b1 && bus_req_in === 1'b1 && bus_wr_in === 1'b0) begin
      if (expq.size() == 0) check(8'hEE, 8'h00, "read with nothing expected");
      else check(bus_rdata_out, expq.pop_front(), "read data");
      check({7'h00, bus_hit_out}, {7'h00, bus_addr_in inside {PS, SC, MS}}, "hit");
      if (bus_addr_in === MS && tpq.size() == 0) check(8'hEE, 8'h00, "stray test pin read");
      else if (bus_addr_in === MS) check(tp_rdata, tpq.pop_front(), "test pin status");
    end
  end

  initial begin
    repeat (5000) @(posedge clk_in);
    miscompares++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    logic [7:0] d;
    logic [7:0] p;
    do_reset(1'b0);
    access(0, PS, 8'h00, MSCR_PERIPH_SEL_RST, 1);
    access(0, SC, 8'h00, MSCR_SYS_CTRL_RST, 1);
    tpq.push_back(MSCR_MODE_STAT_RST);
    access(0, MS, 8'h00, MSCR_MODE_STAT_RST, 0);
    check({7'h00, ram_enable_out}, 8'h01, "ram enable after reset");
    for (int m = 0; m < 4; m++) begin
      mode_strap_hi_in = m[1];
      mode_strap_lo_in = m[0];
      rnd(d);
      test_n_in = d[0];
      // expanded-mode enable never written as one
      d = d & 8'h7F;
      access(1, MS, d, 8'h00, 1);
      tpq.push_back({6'h00, d[0], d[0]});
      access(0, MS, 8'h00, 8'(m), 0);
      check({6'h00, mode_out}, 8'(m), "mode decode");
      check({6'h00, tp_mode}, {6'h00, d[0], d[0]}, "test pin mode");
    end
    mode_strap_hi_in = 1'b1;
    mode_strap_lo_in = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rnd(d);
      // enables 7 and 6 kept clear
      d = d & 8'h3F;
      access(1, SC, d, 8'h00, 1);
      access(0, SC, 8'h00, (d & MSCR_SC_WR_MASK) | 8'h08, 0);
      check({ram_enable_out, nmi_edge_select_out, irq_ctrl_mode_out, chip_select2_enable_out,
             alt_strobe_enable_out, 2'b00}, {d[0], d[2], 2'b00, d[7], d[6], 2'b00}, "sc outputs");
      rnd(p);
      // reserved bits 7 and 3 written as zero
      p = p & 8'h77;
      access(1, PS, p, 8'h00, 1);
      access(0, PS, 8'h00, p, 0);
      check({2'b00, twowire_ctrl_out, usb_access_out, 1'b0, int_clk_sel_out},
            {2'b00, p[6:5], p[2], 1'b0, p[1:0]}, "ps outputs");
    end
    for (int k = 0; k < 4; k++) begin
      access(1, SC, {6'h00, k[0], 1'b1}, 8'h00, 1);
      access(1, PS, {3'h0, k[1], 4'h0}, 8'h00, 0);
      foreach (amap[j]) begin
        bus_addr_in = amap[j];
        #1;
        check({3'h0, timer_access_out, serial_channel0_sel_out, twowire_channel0_sel_out, twowire_channel1_sel_out,
               pulse_width_dac_sel_out}, exp_map(amap[j], k[0], k[1]), "access map");
        @(negedge clk_in);
      end
      check({7'h00, usb_access_out}, 8'h00, "usb blocked");
      @(negedge clk_in);
    end
    access(0, 16'hFFC6, 8'h00, 8'h00, 0);
    access(1, SC, 8'h04, 8'h00, 1);
    access(1, PS, 8'h55, 8'h00, 0);
    // stalled clock enable must hold the access open
    clk_en_in = 1'b0;
    fork
      access(0, SC, 8'h00, 8'h0C, 0);
      begin
        repeat (3) @(negedge clk_in);
        clk_en_in = 1'b1;
      end
    join
    hw_standby_in = 1'b1;
    @(negedge clk_in);
    hw_standby_in = 1'b0;
    access(0, SC, 8'h00, MSCR_SYS_CTRL_RST, 1);
    access(0, PS, 8'h00, MSCR_PERIPH_SEL_RST, 0);
    access(1, SC, 8'h00, 8'h00, 0);
    do_reset(1'b1);
    access(0, SC, 8'h00, 8'h01, 0);
    check({7'h00, ram_enable_out}, 8'h01, "ram enable after watchdog reset");
    do_reset(1'b0);
    access(0, SC, 8'h00, 8'h09, 0);
    conclude();
  end
endmodule // test_mscr_regs
`default_nettype wire
